// [logic/arwl_regs.vh]
// constants for the autorun and wireless lock controller
`ifndef ARWL_REGS_VH
`define ARWL_REGS_VH
`define ARWL_CLK_HZ        10000000
`define ARWL_SEC_CYC       24'd10000000
`define ARWL_COUNT_START   4'h9
`define ARWL_RELOCK_SEC    3'h5
`define ARWL_PRESS_COUNT   3'h6
`define ARWL_BLINK_COUNT   4'hc
`define ARWL_FAST_CYC      24'd1000000
`define ARWL_SLOW_CYC      24'd4000000
`define ARWL_PRESS_GAP_CYC 24'd5000000
`define ARWL_LED_CYC       24'd2500000
`endif

// [logic/arwl_ctrl.v]
// autorun countdown, manual run, erase and wireless lock control
//
// What this block does
// R01 - run offered only with valid stored code
// R02 - startup countdown from 9, one per second
// R03 - countdown zero starts stored user code
// R04 - rocker scroll cancels countdown and autorun
// R05 - rocker press on run executes code
// R06 - erase needs yes then confirming yes
// R07 - erase never touches upper data area
// R08 - load offered only with network and address
// R09 - load unlocks, shows id, blinks leds
// R10 - temp unlock ends on abort or 5s after a download
// R11 - six quick presses toggle persistent unlock
// R12 - confirm blinks: six fast unlock, six slow lock
// R13 - persistent unlock holds until toggled or reset
// R14 - lock pin reads locked by default
// R15 - pin low relocks within 5s after transaction
// R16 - locked device rejects all downloads
// R17 - loads and settings only while unlocked
// R18 - unlock is or of three sources
`timescale 1ns/10ps
`default_nettype none
`include "arwl_regs.vh"
module arwl_ctrl (
  input  wire       mclk,
  input  wire       resetn,
  input  wire       code_valid,      // valid code sits in the lower code area
  input  wire       wifi_up,         // network joined with a valid address
  input  wire       rock_left,       // right rocker moved left, one-cycle pulse
  input  wire       rock_right,      // right rocker moved right, one-cycle pulse
  input  wire       rock_press,      // right rocker pressed in, one-cycle pulse
  input  wire       left_press,      // left rocker pressed in (yes), pulse
  input  wire       pwr_btn,         // power button level, high while pressed
  input  wire       lock_pin,        // lock request pin, high requests unlock
  input  wire       dl_req,          // host asks to download or change settings
  input  wire       dl_busy,         // a wireless transaction is in progress
  input  wire       dl_done,         // a code download finished, pulse
  output reg        run_code,        // start user code, pulse
  output reg        erase_lower,     // invalidate lower code area, pulse
  output reg  [3:0] count_show,      // countdown value shown
  output reg        count_active,    // countdown running
  output reg  [2:0] menu_item,       // menu item on display
  output reg        show_id,         // show the identification code
  output reg        led0,            // user led 0
  output reg        led1,            // user led 1
  output reg        pwr_led,         // power led
  output reg        unlocked,        // effective unlock state
  output reg        dl_accept,       // download or settings change taken, pulse
  output reg        dl_reject        // download refused, pulse
);
  // menu items, one-hot
  localparam [2:0] M_RUN   = 3'h1;
  localparam [2:0] M_LOAD  = 3'h2;
  localparam [2:0] M_ADMIN = 3'h4;
  // erase dialogue states, one-hot
  localparam [2:0] E_IDLE = 3'h1;
  localparam [2:0] E_ASK  = 3'h2;
  localparam [2:0] E_SURE = 3'h4;

  reg        rs_a;       // reset release stage 1
  reg        rst_n;      // reset release stage 2
  reg [23:0] sec_cnt;    // one second prescaler
  reg        temp_unl;   // unlock from the load menu
  reg        pers_unl;   // unlock from the power button
  reg        pin_unl;    // unlock from the lock pin, delayed release
  reg [2:0]  pin_secs;   // seconds since lock pin fell
  reg [2:0]  tmo_secs;   // seconds since download done
  reg        tmo_run;    // post download relock timer active
  reg [2:0]  erase_st;   // erase dialogue state
  reg [2:0]  press_n;    // power presses counted
  reg [23:0] gap_cnt;    // time since last press
  reg        btn_q;      // power button last cycle
  reg [3:0]  blink_n;    // blink half periods left
  reg [23:0] blink_cnt;  // blink half period timer
  reg        blink_fast; // fast pattern confirms unlock
  reg [23:0] led_cnt;    // user led alternation timer
  reg        boot_seen;  // first active cycle after reset has passed

  // one pulse per second; the prescaler runs free, so the first step of a relock
  // timer may come early, traded for a single timer shared by all users
  wire tick = (sec_cnt == `ARWL_SEC_CYC - 24'd1);
  wire scroll = rock_left | rock_right;
  wire pin_hi = lock_pin; // external pull-down makes idle read low = locked [R14]

  // next menu item when scrolled; run and load are skipped when not offered
  function [2:0] next_item;
    input [2:0] cur;
    input       has_code;
    input       has_net;
    begin
      case (cur)
        M_RUN:   next_item = has_net ? M_LOAD : M_ADMIN;            // [R08]
        M_LOAD:  next_item = M_ADMIN;
        M_ADMIN: next_item = has_code ? M_RUN : (has_net ? M_LOAD : M_ADMIN); // [R01]
        default: next_item = M_ADMIN;
      endcase
    end
  endfunction

  // two flip-flop reset release
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rs_a  <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs_a  <= 1'b1;
      rst_n <= rs_a;
    end
  end

  // free running second tick
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      sec_cnt <= 24'h0;
    else if (tick)
      sec_cnt <= 24'h0;
    else
      sec_cnt <= sec_cnt + 24'd1;
  end

  // menu, countdown, run, load and erase dialogue
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_show   <= `ARWL_COUNT_START;
      count_active <= 1'b0;
      menu_item    <= M_ADMIN;
      run_code     <= 1'b0;
      erase_lower  <= 1'b0;
      temp_unl     <= 1'b0;
      show_id      <= 1'b0;
      erase_st     <= E_IDLE;
      tmo_run      <= 1'b0;
      tmo_secs     <= 3'h0;
      boot_seen    <= 1'b0;
    end else begin
      run_code    <= 1'b0;
      erase_lower <= 1'b0;
      boot_seen   <= 1'b1;
      // first cycle after reset: countdown only when code is valid; code that
      // arrives later by download never starts an autorun nobody asked for
      if (!boot_seen && code_valid) begin
        menu_item    <= M_RUN;                      // [R01]
        count_active <= 1'b1;                       // [R02]
        count_show   <= `ARWL_COUNT_START;          // [R02]
      end
      if (temp_unl) begin
        // load screen: abort with rocker press, or timeout after a download
        if (rock_press) begin
          temp_unl <= 1'b0;                         // [R10]
          show_id  <= 1'b0;
          tmo_run  <= 1'b0;
        end else if (dl_done) begin
          tmo_run  <= 1'b1;
          tmo_secs <= 3'h0;
        end else if (tmo_run && tick) begin
          if (tmo_secs == `ARWL_RELOCK_SEC - 3'h1) begin
            temp_unl <= 1'b0;                       // [R10]
            show_id  <= 1'b0;
            tmo_run  <= 1'b0;
          end else
            tmo_secs <= tmo_secs + 3'h1;
        end
      end else if (erase_st != E_IDLE) begin
        // each answer is a one-cycle pulse; with no answer the question stands
        case (erase_st)
          E_ASK:  erase_st <= left_press ? E_SURE : (rock_press ? E_IDLE : E_ASK);
          E_SURE: begin
            if (left_press) begin
              erase_lower <= 1'b1; // lower area only, upper data kept [R06] [R07]
              erase_st    <= E_IDLE;
            end else if (rock_press)
              erase_st <= E_IDLE;
          end
          default: erase_st <= E_IDLE;
        endcase
      end else if (scroll) begin
        // the shown count drops to zero, so scrolling back to run never
        // resumes a countdown that was cancelled
        count_active <= 1'b0;                       // [R04]
        count_show   <= 4'h0;
        menu_item    <= next_item(menu_item, code_valid, wifi_up);
      end else if (rock_press) begin
        count_active <= 1'b0;
        case (menu_item)
          M_RUN:   run_code <= code_valid;          // [R05] [R01]
          M_LOAD:  if (wifi_up) begin               // [R08]
            temp_unl <= 1'b1;                       // [R09]
            show_id  <= 1'b1;                       // [R09]
          end
          M_ADMIN: erase_st <= E_ASK;               // [R06]
          default: menu_item <= M_ADMIN;
        endcase
      end else if (count_active && tick) begin
        if (count_show == 4'h1 || count_show == 4'h0) begin
          count_active <= 1'b0;
          count_show   <= 4'h0;
          // code that vanished during the count is never started
          run_code     <= code_valid;               // [R03] [R01]
        end else
          count_show <= count_show - 4'h1;          // [R02]
      end
    end
  end

  // six-press power button toggle and confirm blinks
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      btn_q      <= 1'b0;
      press_n    <= 3'h0;
      gap_cnt    <= 24'h0;
      pers_unl   <= 1'b0;
      blink_n    <= 4'h0;
      blink_cnt  <= 24'h0;
      blink_fast <= 1'b0;
      pwr_led    <= 1'b0;
    end else begin
      // the edge detector resets low, the idle level of the button, so no
      // false press follows reset
      btn_q <= pwr_btn;
      if (blink_n != 4'h0) begin
        // presses are ignored while confirming
        if (blink_cnt == (blink_fast ? `ARWL_FAST_CYC : `ARWL_SLOW_CYC)) begin
          blink_cnt <= 24'h0;
          blink_n   <= blink_n - 4'h1;
          pwr_led   <= ~pwr_led;                    // [R12]
        end else
          blink_cnt <= blink_cnt + 24'd1;
      end else begin
        pwr_led <= pwr_btn;                         // led on while pressed [R11]
        if (pwr_btn && !btn_q) begin
          gap_cnt <= 24'h0;
          if (press_n == `ARWL_PRESS_COUNT - 3'h1) begin
            press_n    <= 3'h0;
            pers_unl   <= ~pers_unl;                // holds until next toggle [R11] [R13]
            blink_fast <= ~pers_unl;                // [R12]
            blink_n    <= `ARWL_BLINK_COUNT;
            blink_cnt  <= 24'h0;
          end else
            press_n <= press_n + 3'h1;
        end else if (press_n != 3'h0) begin
          // presses too far apart restart the count
          if (gap_cnt == `ARWL_PRESS_GAP_CYC)
            press_n <= 3'h0;
          else
            gap_cnt <= gap_cnt + 24'd1;
        end
      end
    end
  end

  // lock pin: unlock at once, relock up to 5 s after it falls
  // the pin is taken as synchronous; a slow edge only costs one cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_unl  <= 1'b0;
      pin_secs <= 3'h0;
    end else if (pin_hi) begin
      pin_unl  <= 1'b1;                             // [R14]
      pin_secs <= 3'h0;
    end else if (pin_unl && tick) begin
      // waits for the transaction, but never past the limit
      if (!dl_busy || pin_secs == `ARWL_RELOCK_SEC - 3'h1) begin
        pin_unl  <= 1'b0;                           // [R15]
        pin_secs <= 3'h0;
      end else
        pin_secs <= pin_secs + 3'h1;
    end
  end

  // effective lock and host gate, user led alternation
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked  <= 1'b0;
      dl_accept <= 1'b0;
      dl_reject <= 1'b0;
      led_cnt   <= 24'h0;
      led0      <= 1'b0;
      led1      <= 1'b0;
    end else begin
      unlocked  <= temp_unl | pers_unl | pin_unl;   // [R18]
      // a locked device refuses everything, unlock code included
      // the gate uses the registered state, so the answer always agrees with
      // the unlocked level that the host sees beside its request
      dl_accept <= dl_req & unlocked;               // [R17]
      dl_reject <= dl_req & ~unlocked;              // [R16] [R17]
      if (temp_unl) begin
        if (led_cnt == `ARWL_LED_CYC) begin
          led_cnt <= 24'h0;
          led0    <= ~led0;                         // [R09]
          led1    <= led0;
        end else begin
          led_cnt <= led_cnt + 24'd1;
          // led0 lights on the first cycle so the pattern shows at once
          if (!led0 && !led1)
            led0 <= 1'b1;
        end
      end else begin
        led_cnt <= 24'h0;
        led0    <= 1'b0;
        led1    <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/arwl_ctrl_monitor.sv]
// assertion checker for the autorun and wireless lock controller ports
`timescale 1ns/10ps
`default_nettype none
module arwl_ctrl_monitor (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       code_valid,
  input wire logic       wifi_up,
  input wire logic       rock_left,
  input wire logic       rock_right,
  input wire logic       rock_press,
  input wire logic       pwr_btn,
  input wire logic       lock_pin,
  input wire logic       dl_req,
  input wire logic       run_code,
  input wire logic       erase_lower,
  input wire logic       left_press,
  input wire logic       count_active,
  input wire logic [2:0] menu_item,
  input wire logic       show_id,
  input wire logic       pwr_led,
  input wire logic       unlocked,
  input wire logic       dl_accept,
  input wire logic       dl_reject
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_locked_reject: assert property (dl_req && !unlocked |=> dl_reject && !dl_accept)
    else $error("locked request not refused");
  chk_open_accept: assert property (dl_req && unlocked |=> dl_accept && !dl_reject)
    else $error("unlocked request not taken");
  chk_pin_unlock: assert property ($rose(lock_pin) |-> ##[1:4] unlocked)
    else $error("lock pin high did not unlock");
  chk_scroll_cancel: assert property (count_active && (rock_left || rock_right) |-> ##[1:2] !count_active)
    else $error("scroll left the countdown running");
  chk_run_press: assert property (menu_item == 3'h1 && rock_press && code_valid |=> run_code)
    else $error("press on run did not start code");
  chk_run_code: assert property (run_code |-> $past(code_valid))
    else $error("code started without valid code");
  chk_erase_yes: assert property (erase_lower |-> $past(left_press))
    else $error("erase without a confirming yes");
  chk_load_net: assert property ($rose(show_id) |-> $past(wifi_up))
    else $error("load screen without network");
  chk_press_led: assert property ($rose(pwr_btn) && !pwr_led |-> ##[1:3] pwr_led)
    else $error("power led dark during a press");
endmodule
bind arwl_ctrl arwl_ctrl_monitor u_mon (.mclk, .resetn, .code_valid, .wifi_up, .rock_left,
  .rock_right, .rock_press, .pwr_btn, .lock_pin, .dl_req, .run_code, .erase_lower, .left_press,
  .count_active, .menu_item, .show_id, .pwr_led, .unlocked, .dl_accept, .dl_reject);
`default_nettype wire

// [verif/arwl_host.sv]
// wireless programming host model: asks for a download and notes the answer
`timescale 1ns/10ps
`default_nettype none
module arwl_host (
  input  wire logic mclk,
  input  wire logic dl_accept,
  input  wire logic dl_reject,
  output var logic  dl_req = 1'b0,
  output var logic  dl_busy = 1'b0,
  output var logic  dl_done = 1'b0,
  output var logic  got_acc = 1'b0,
  output var logic  got_rej = 1'b0
);
  logic clr_flags = 1'b0; // clears the answer flags as a request goes out
  // sticky answer flags, since the answers last one cycle only
  always @(posedge mclk) begin
    if (clr_flags) begin
      got_acc <= 1'b0;
      got_rej <= 1'b0;
    end else begin
      if (dl_accept) got_acc <= 1'b1;
      if (dl_reject) got_rej <= 1'b1;
    end
  end
  // one request; a taken download runs a short busy spell, then reports done
  task xfer;
    @(negedge mclk);
    clr_flags = 1'b1;
    dl_req = 1'b1;
    @(negedge mclk);
    clr_flags = 1'b0;
    dl_req = 1'b0;
    repeat (2) @(negedge mclk);
    if (got_acc) begin
      dl_busy = 1'b1;
      repeat (3) @(negedge mclk);
      dl_busy = 1'b0;
      dl_done = 1'b1;
      @(negedge mclk);
      dl_done = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [verif/test_arwl_ctrl.sv]
// self-checking bench for the autorun and wireless lock controller
`timescale 1ns/10ps
`default_nettype none
module test_arwl_ctrl;
  logic       mclk = 1'b0;    // 10 MHz system clock
  logic       resetn = 1'b0;  // held low for ten cycles
  logic       code_valid = 1'b1, wifi_up = 1'b1, lock_pin = 1'b0, pwr_btn = 1'b0;
  logic       rock_left = 1'b0, rock_right = 1'b0, rock_press = 1'b0, left_press = 1'b0;
  logic       seen_run = 1'b0, seen_erase = 1'b0;
  wire        dl_req, dl_busy, dl_done, got_acc, got_rej, run_code, erase_lower;
  wire        count_active, show_id, led0, led1, pwr_led, unlocked, dl_accept, dl_reject;
  wire  [3:0] count_show;
  wire  [2:0] menu_item;
  int         n_fail = 0, checks = 0, cyc = 0;
  always #50 mclk = ~mclk;
  arwl_ctrl DUT (.mclk, .resetn, .code_valid, .wifi_up, .rock_left, .rock_right, .rock_press,
    .left_press, .pwr_btn, .lock_pin, .dl_req, .dl_busy, .dl_done, .run_code, .erase_lower,
    .count_show, .count_active, .menu_item, .show_id, .led0, .led1, .pwr_led, .unlocked,
    .dl_accept, .dl_reject);
  arwl_host u_host (.mclk, .dl_accept, .dl_reject, .dl_req, .dl_busy, .dl_done, .got_acc, .got_rej);
  // catch one-cycle pulses; a hang is cut short well past the expected run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (run_code) seen_run <= 1'b1;
    if (erase_lower) seen_erase <= 1'b1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // 0 scrolls right, 1 presses the right rocker, else answers yes
  task btn(input int k);
    @(negedge mclk);
    case (k)
      0: rock_right = 1'b1;
      1: rock_press = 1'b1;
      default: left_press = 1'b1;
    endcase
    @(negedge mclk);
    {rock_right, rock_press, left_press} = 3'h0;
    repeat (3) @(negedge mclk);
  endtask
  task goto(input logic [2:0] t);
    repeat (4) if (menu_item !== t) btn(0);
    chk("menu item", {1'b0, t}, {1'b0, menu_item});
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    chk("count reset", 4'h9, count_show);
    resetn = 1'b1;
    repeat (6) @(negedge mclk);
    chk("countdown on", 4'h1, {3'h0, count_active});
    u_host.xfer();
    chk("locked reject", 4'h1, {3'h0, got_rej});
    chk("locked no accept", 4'h0, {3'h0, got_acc});
    btn(0);
    chk("scroll cancel", 4'h0, {3'h0, count_active});
    goto(3'h1);
    chk("no autorun", 4'h0, {3'h0, seen_run});
    btn(1);
    chk("manual run", 4'h1, {3'h0, seen_run});
    $display("test run menu done");
    goto(3'h2);
    btn(1);
    chk("load unlock", 4'h3, {2'h0, show_id, unlocked});
    chk("load leds", 4'h1, {2'h0, led1, led0});
    u_host.xfer();
    chk("temp accept", 4'h1, {3'h0, got_acc});
    btn(1);
    chk("abort relock", 4'h0, {3'h0, unlocked});
    lock_pin = 1'b1;
    repeat (4) @(negedge mclk);
    chk("pin unlock", 4'h1, {3'h0, unlocked});
    u_host.xfer();
    chk("pin accept", 4'h1, {3'h0, got_acc});
    lock_pin = 1'b0;
    $display("test unlock sources done");
    // a power cycle in mid run drops every unlock and restarts the countdown
    resetn = 1'b0;
    repeat (3) @(negedge mclk);
    chk("reset lock", 4'h0, {3'h0, unlocked});
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    chk("restart count", 4'h9, count_show);
    chk("restart active", 4'h1, {3'h0, count_active});
    chk("restart run", 4'h1, {1'b0, menu_item});
    goto(3'h4);
    btn(1);
    btn(2);
    chk("erase early", 4'h0, {3'h0, seen_erase});
    btn(2);
    chk("erase done", 4'h1, {3'h0, seen_erase});
    repeat (6) begin
      pwr_btn = 1'b1;
      repeat (3) @(negedge mclk);
      chk("press led", 4'h1, {3'h0, pwr_led});
      pwr_btn = 1'b0;
      repeat (4) @(negedge mclk);
    end
    chk("power unlock", 4'h1, {3'h0, unlocked});
    u_host.xfer();
    chk("held accept", 4'h1, {3'h0, got_acc});
    $display("test erase and power done");
    stop_test();
  end
endmodule
`default_nettype wire
